// ---- logic/fst_skip_unit.sv ----
// skip-test decoder with request flags, apb registers and event interrupt
`timescale 1ns/1ps
// Notes on behaviour
// - converter skip clears flag when enable low
// - converter enable high makes it nop
// - converter enable is second control bit 2
// - ext0 skip on level chosen by polarity
// - ext1 skip on level chosen by polarity
// - power-down skip leaves flag unchanged
// - serial skip clears flag, nop if enabled
// - timer1 skip clears flag when enable low
// - timer2 skip clears flag when enable low
// - timer3 skip clears flag when enable low
// - timer4 enable is second control bit 1
// - timer enable high makes skip a nop
// - serial start clears flag, starts transfer
// - memory bit zero skips next instruction
module fst_skip_unit import fst_pkg::*; #(
    parameter int AW = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instrValid,
    input wire logic [9:0] instrWord,
    output logic instrSuppress,
    output logic skipNow,
    input wire logic [AW-1:0] dataPointer,
    input wire logic memWrEn,
    input wire logic [AW-1:0] memWrAddr,
    input wire logic [3:0] memWrData,
    input wire logic extInputZeroPin,
    input wire logic extInputOnePin,
    input wire logic powerDownFlag,
    input wire logic convDoneSet,
    input wire logic serialDoneSet,
    input wire logic [3:0] timerSet,
    output logic convDoneFlag,
    output logic serialDoneFlag,
    output logic [3:0] timerRequestFlag,
    output logic serialStart,
    output logic irq
);
    typedef struct packed {
        logic [3:0] intCtrlFirst;
        logic [3:0] intCtrlSecond;
        logic [3:0] ext0Ctrl;
        logic [3:0] ext1Ctrl;
        logic convFlag;
        logic serialFlag;
        logic [3:0] timerFlag;
        logic [9:0] instr;
        logic valid;
        logic skip;
        logic serialStart;
        logic [EV_W-1:0] evStat;
        logic [EV_W-1:0] evEn;
        logic [31:0] prdata;
    } fst_state_s;

    fst_state_s state_q, state_d;
    logic [3:0] memNibble;
    logic [3:0] timerEn;
    logic [3:0] timerHit;
    logic [3:0] timerClr;
    logic convHit, ext0Hit, ext1Hit, pwrHit, serialHit, memHit;
    logic isConv, isSerial, isSst, isMem;
    logic apbWr, apbRd, mapped;
    logic [EV_W-1:0] evSet, evClr;

    fst_nibble_mem #(.AW(AW), .DW(4)) u_mem (
        .clk(clk),
        .rst(rst),
        .wrEn(memWrEn),
        .wrAddr(memWrAddr),
        .wrData(memWrData),
        .rdAddr(dataPointer),
        .rdData(memNibble)
    );

    // decode of the instruction held in the execute stage
    assign isConv = state_q.valid && state_q.instr == OP_SKIP_CONV;
    assign isSerial = state_q.valid && state_q.instr == OP_SKIP_SERIAL;
    assign isSst = state_q.valid && state_q.instr == OP_SERIAL_START;
    assign isMem = state_q.valid && state_q.instr[9:2] == OP_SKIP_MEMBIT_HI;

    assign timerEn = {state_q.intCtrlSecond[BIT_T4_EN],
                      state_q.intCtrlSecond[BIT_T3_EN],
                      state_q.intCtrlFirst[BIT_T2_EN],
                      state_q.intCtrlFirst[BIT_T1_EN]};

    // enable high turns the test into a nop that leaves the flag alone
    assign convHit = isConv && !state_q.intCtrlSecond[BIT_CONV_EN]
                     && state_q.convFlag;
    assign serialHit = isSerial && !state_q.intCtrlSecond[BIT_SERIAL_EN]
                       && state_q.serialFlag;
    assign ext0Hit = state_q.valid && state_q.instr == OP_SKIP_EXT0
                     && (extInputZeroPin == state_q.ext0Ctrl[BIT_EDGE_SEL]);
    assign ext1Hit = state_q.valid && state_q.instr == OP_SKIP_EXT1
                     && (extInputOnePin == state_q.ext1Ctrl[BIT_EDGE_SEL]);
    assign pwrHit = state_q.valid && state_q.instr == OP_SKIP_PWRDN
                    && powerDownFlag;
    assign memHit = isMem && !memNibble[state_q.instr[1:0]];

    for (genvar t = 0; t < 4; t++) begin : g_timer
        assign timerHit[t] = state_q.valid
                             && state_q.instr == OP_SKIP_TIMER1 + 10'(t)
                             && !timerEn[t] && state_q.timerFlag[t];
        assign timerClr[t] = timerHit[t];
    end

    assign skipNow = convHit | serialHit | ext0Hit | ext1Hit | pwrHit | memHit
                     | (|timerHit);
    // a skip decided this cycle must already hold back a word fetched now
    assign instrSuppress = instrValid && (state_q.skip || skipNow);

    assign apbWr = psel && penable && pwrite;
    assign apbRd = psel && !penable && !pwrite;
    always_comb begin
        case (paddr)
            OFS_INT_CTRL_FIRST, OFS_INT_CTRL_SECOND, OFS_EXT0_CTRL, OFS_EXT1_CTRL,
            OFS_FLAGS, OFS_EV_STATUS, OFS_EV_ENABLE, OFS_EV_CLEAR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign evSet = {skipNow, timerSet, serialDoneSet, convDoneSet};
    assign evClr = (apbWr && paddr == OFS_EV_CLEAR) ? pwdata[EV_W-1:0] : '0;

    always_comb begin
        state_d = state_q;
        state_d.serialStart = 1'b0;
        // fetch stage: a suppressed word uses its slot and changes nothing
        state_d.valid = instrValid && !instrSuppress;
        state_d.instr = instrWord;
        if (instrValid) begin
            state_d.skip = 1'b0;
        end else if (skipNow) begin
            state_d.skip = 1'b1;
        end
        // clears first, hardware sets afterwards so a set always wins
        if (convHit) begin
            state_d.convFlag = 1'b0;
        end
        if (serialHit || isSst) begin
            state_d.serialFlag = 1'b0;
        end
        state_d.timerFlag = state_q.timerFlag & ~timerClr;
        if (isSst) begin
            state_d.serialStart = 1'b1;
        end
        if (convDoneSet) begin
            state_d.convFlag = 1'b1;
        end
        if (serialDoneSet) begin
            state_d.serialFlag = 1'b1;
        end
        state_d.timerFlag = state_d.timerFlag | timerSet;
        state_d.evStat = (state_q.evStat & ~evClr) | evSet;
        if (apbWr) begin
            case (paddr)
                OFS_INT_CTRL_FIRST: state_d.intCtrlFirst = pwdata[3:0];
                OFS_INT_CTRL_SECOND: state_d.intCtrlSecond = pwdata[3:0];
                OFS_EXT0_CTRL: state_d.ext0Ctrl = pwdata[3:0];
                OFS_EXT1_CTRL: state_d.ext1Ctrl = pwdata[3:0];
                OFS_EV_ENABLE: state_d.evEn = pwdata[EV_W-1:0];
                default: ;
            endcase
        end
        // read data is captured in the setup cycle so it leaves a flop
        if (apbRd) begin
            case (paddr)
                OFS_INT_CTRL_FIRST: state_d.prdata = {28'h0, state_q.intCtrlFirst};
                OFS_INT_CTRL_SECOND: state_d.prdata = {28'h0, state_q.intCtrlSecond};
                OFS_EXT0_CTRL: state_d.prdata = {28'h0, state_q.ext0Ctrl};
                OFS_EXT1_CTRL: state_d.prdata = {28'h0, state_q.ext1Ctrl};
                OFS_FLAGS: state_d.prdata = {26'h0, state_q.timerFlag,
                                             state_q.serialFlag, state_q.convFlag};
                OFS_EV_STATUS: state_d.prdata = {25'h0, state_q.evStat};
                OFS_EV_ENABLE: state_d.prdata = {25'h0, state_q.evEn};
                default: state_d.prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= '{intCtrlFirst: RST_CTRL, intCtrlSecond: RST_CTRL,
                         ext0Ctrl: RST_CTRL, ext1Ctrl: RST_CTRL,
                         evStat: RST_EV, evEn: RST_EV, default: '0};
        end else begin
            state_q <= state_d;
        end
    end

    assign prdata = state_q.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign convDoneFlag = state_q.convFlag;
    assign serialDoneFlag = state_q.serialFlag;
    assign timerRequestFlag = state_q.timerFlag;
    assign serialStart = state_q.serialStart;
    assign irq = |(state_q.evStat & state_q.evEn);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence sConvTest;
        isConv && !state_q.intCtrlSecond[BIT_CONV_EN] && state_q.convFlag;
    endsequence
    sequence sSkipHeld;
        skipNow && !instrValid ##1 instrValid;
    endsequence
    sequence sSerialArmed;
        isSerial && !state_q.intCtrlSecond[BIT_SERIAL_EN];
    endsequence
    sequence sStartIssued;
        isSst && !serialDoneSet;
    endsequence

    a_conv_skip_clear: assert property (sConvTest ##0 !convDoneSet |-> skipNow ##1 !convDoneFlag)
        else $error("converter skip did not skip and clear");
    a_conv_nop_hold: assert property (isConv && state_q.intCtrlSecond[2] && !convDoneSet
        |-> !skipNow ##1 convDoneFlag == $past(convDoneFlag))
        else $error("enabled converter test not a nop");
    a_ext0_level: assert property (state_q.valid && state_q.instr == OP_SKIP_EXT0
        |-> skipNow == (extInputZeroPin == state_q.ext0Ctrl[2]))
        else $error("ext0 level skip wrong");
    a_ext1_level: assert property (state_q.valid && state_q.instr == OP_SKIP_EXT1
        |-> skipNow == (extInputOnePin == state_q.ext1Ctrl[2]))
        else $error("ext1 level skip wrong");
    a_power_skip: assert property (state_q.valid && state_q.instr == OP_SKIP_PWRDN
        |-> skipNow == powerDownFlag)
        else $error("power-down skip wrong");
    a_serial_skip: assert property (isSerial && !state_q.intCtrlSecond[3] && serialDoneFlag
        && !serialDoneSet |-> skipNow ##1 !serialDoneFlag)
        else $error("serial skip did not clear");
    a_timer4_gate: assert property (state_q.valid && state_q.instr == 10'h283
        && state_q.intCtrlSecond[1] && !timerSet[3]
        |-> !skipNow ##1 $stable(timerRequestFlag[3]))
        else $error("enabled timer4 test not a nop");
    a_timer1_skip: assert property (state_q.valid && state_q.instr == OP_SKIP_TIMER1
        && !state_q.intCtrlFirst[2] && timerRequestFlag[0] && !timerSet[0]
        |-> skipNow ##1 !timerRequestFlag[0])
        else $error("timer1 skip did not clear");
    a_serial_start: assert property (isSst && !serialDoneSet
        |=> serialStart && !serialDoneFlag)
        else $error("serial start missing");
    a_mem_bit: assert property (isMem |-> skipNow == !memNibble[state_q.instr[1:0]])
        else $error("memory bit skip wrong");
    a_skip_suppress: assert property (sSkipHeld |-> instrSuppress ##1 !state_q.valid)
        else $error("skipped word not suppressed");

    // remaining timer tests, one per request flag, then converter, serial and serial start checks
    a_timer2_skip: assert property (state_q.valid && state_q.instr == 10'h281
        && !state_q.intCtrlFirst[BIT_T2_EN] && timerRequestFlag[1] && !timerSet[1]
        |-> skipNow ##1 !timerRequestFlag[1])
        else $error("timer2 skip did not clear");
    a_timer3_skip: assert property (state_q.valid && state_q.instr == 10'h282
        && !state_q.intCtrlSecond[BIT_T3_EN] && timerRequestFlag[2] && !timerSet[2]
        |-> skipNow ##1 !timerRequestFlag[2])
        else $error("timer3 skip did not clear");
    a_timer4_skip: assert property (state_q.valid && state_q.instr == 10'h283
        && !state_q.intCtrlSecond[BIT_T4_EN] && timerRequestFlag[3] && !timerSet[3]
        |-> skipNow ##1 !timerRequestFlag[3])
        else $error("timer4 skip did not clear");
    a_timer1_nop: assert property (state_q.valid && state_q.instr == OP_SKIP_TIMER1
        && state_q.intCtrlFirst[BIT_T1_EN] && !timerSet[0]
        |-> !skipNow ##1 $stable(timerRequestFlag[0]))
        else $error("enabled timer1 test not a nop");
    a_conv_en_bit: assert property (isConv && state_q.intCtrlSecond[BIT_CONV_EN]
        |-> !skipNow)
        else $error("converter enable bit ignored");
    a_serial_nop: assert property (isSerial && state_q.intCtrlSecond[BIT_SERIAL_EN]
        && !serialDoneSet |-> !skipNow ##1 $stable(serialDoneFlag))
        else $error("enabled serial test not a nop");
    a_serial_armed: assert property (sSerialArmed ##0 serialDoneFlag
        |-> skipNow)
        else $error("armed serial test did not skip");
    a_start_clear: assert property (sStartIssued
        |=> !serialDoneFlag)
        else $error("serial start left flag set");
    a_start_pulse: assert property (!isSst
        |=> !serialStart)
        else $error("serial start without instruction");

    // hardware sets must win over a clear in the same cycle; a suppressed word never reaches execute
    a_conv_set_wins: assert property (convDoneSet
        |=> convDoneFlag)
        else $error("converter set lost");
    a_serial_set_wins: assert property (serialDoneSet
        |=> serialDoneFlag)
        else $error("serial set lost");
    a_timer_set_wins: assert property (timerSet[3]
        |=> timerRequestFlag[3])
        else $error("timer4 set lost");
    a_suppress_dead: assert property (instrSuppress
        |=> !state_q.valid)
        else $error("suppressed word reached execute");
    a_skip_event: assert property (skipNow
        |=> state_q.evStat[EV_SKIP])
        else $error("skip event not recorded");
endmodule : fst_skip_unit

// ---- common/fst_pkg.sv ----
// constants for the flag skip test unit
package fst_pkg;
    // instruction codes, 10 bits
    localparam logic [9:0] OP_SKIP_CONV = 10'h287;
    localparam logic [9:0] OP_SKIP_EXT0 = 10'h03a;
    localparam logic [9:0] OP_SKIP_EXT1 = 10'h03b;
    localparam logic [9:0] OP_SKIP_PWRDN = 10'h003;
    localparam logic [9:0] OP_SKIP_SERIAL = 10'h288;
    localparam logic [9:0] OP_SKIP_TIMER1 = 10'h280;
    localparam logic [9:0] OP_SERIAL_START = 10'h29e;
    localparam logic [7:0] OP_SKIP_MEMBIT_HI = 8'h08;
    // byte offsets on the register bus
    localparam logic [7:0] OFS_INT_CTRL_FIRST = 8'h00;
    localparam logic [7:0] OFS_INT_CTRL_SECOND = 8'h04;
    localparam logic [7:0] OFS_EXT0_CTRL = 8'h08;
    localparam logic [7:0] OFS_EXT1_CTRL = 8'h0c;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [7:0] OFS_EV_STATUS = 8'h14;
    localparam logic [7:0] OFS_EV_ENABLE = 8'h18;
    localparam logic [7:0] OFS_EV_CLEAR = 8'h1c;
    // field positions
    localparam int BIT_T1_EN = 2;
    localparam int BIT_T2_EN = 3;
    localparam int BIT_T3_EN = 0;
    localparam int BIT_T4_EN = 1;
    localparam int BIT_CONV_EN = 2;
    localparam int BIT_SERIAL_EN = 3;
    localparam int BIT_EDGE_SEL = 2;
    localparam int EV_CONV = 0;
    localparam int EV_SERIAL = 1;
    localparam int EV_TIMER0 = 2;
    localparam int EV_SKIP = 6;
    localparam int EV_W = 7;
    // values after reset
    localparam logic [3:0] RST_CTRL = 4'h0;
    localparam logic [EV_W-1:0] RST_EV = 7'h00;
endpackage : fst_pkg

// ---- logic/fst_nibble_mem.sv ----
// small data memory with registered read port
`timescale 1ns/1ps
module fst_nibble_mem #(
    parameter int AW = 6,
    parameter int DW = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [DW-1:0] wrData,
    input wire logic [AW-1:0] rdAddr,
    output logic [DW-1:0] rdData
);
    typedef struct packed {
        logic [DW-1:0] rdData;
    } fst_mem_state_s;

    fst_mem_state_s state_q, state_d;
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // the array itself is not reset, only the read register
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_comb begin
        state_d = state_q;
        state_d.rdData = mem[rdAddr];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign rdData = state_q.rdData;
endmodule : fst_nibble_mem

// ---- dv/flag_skip_test_unit_bench.sv ----
// self-checking bench for the skip-test decoder
`timescale 1ns/1ps
module flag_skip_test_unit_bench;
    import fst_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic instrValid, instrSuppress, skipNow, memWrEn, extInputZeroPin, extInputOnePin;
    logic [9:0] instrWord;
    logic [5:0] dataPointer, memWrAddr;
    logic [3:0] memWrData, timerSet, timerRequestFlag;
    logic powerDownFlag, convDoneSet, serialDoneSet, convDoneFlag, serialDoneFlag;
    logic serialStart, irq, errv, pend;
    int err_count, cmp_count;

    fst_skip_unit fst_skip_unit_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instrValid(instrValid), .instrWord(instrWord),
        .instrSuppress(instrSuppress), .skipNow(skipNow), .dataPointer(dataPointer),
        .memWrEn(memWrEn), .memWrAddr(memWrAddr), .memWrData(memWrData),
        .extInputZeroPin(extInputZeroPin), .extInputOnePin(extInputOnePin),
        .powerDownFlag(powerDownFlag), .convDoneSet(convDoneSet),
        .serialDoneSet(serialDoneSet), .timerSet(timerSet), .convDoneFlag(convDoneFlag),
        .serialDoneFlag(serialDoneFlag), .timerRequestFlag(timerRequestFlag),
        .serialStart(serialStart), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task print_verdict;
        if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // pready is sampled with psel and penable at the edge that ends the access
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) err_count++;
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] flags();
        return 32'({timerRequestFlag, serialDoneFlag, convDoneFlag});
    endfunction : flags

    task setf(input logic c, input logic s, input logic [3:0] t);
        @(posedge clk);
        convDoneSet <= c; serialDoneSet <= s; timerSet <= t;
        @(posedge clk);
        convDoneSet <= 1'b0; serialDoneSet <= 1'b0; timerSet <= 4'h0;
        @(posedge clk);
    endtask : setf

    // a word following a skip must come back suppressed and without effect
    task issue(input logic [9:0] w, input logic expSkip);
        @(posedge clk);
        instrValid <= 1'b1; instrWord <= w;
        #1 check(32'(instrSuppress), 32'(pend));
        @(posedge clk);
        instrValid <= 1'b0;
        #1 check(32'(skipNow), 32'(expSkip & ~pend));
        pend = expSkip & ~pend;
        @(posedge clk);
        #1;
    endtask : issue

    task t_conv_serial;
        setf(1'b1, 1'b1, 4'h0);
        apb(1'b1, OFS_INT_CTRL_SECOND, 32'(1) << BIT_CONV_EN);
        issue(OP_SKIP_CONV, 1'b0);
        check(flags(), 32'h03);
        apb(1'b1, OFS_INT_CTRL_SECOND, 32'h0);
        issue(OP_SKIP_CONV, 1'b1);
        check(flags(), 32'h02);
        issue(OP_SERIAL_START, 1'b0);
        check(32'(serialStart), 32'h0);
        check(flags(), 32'h02);
        apb(1'b1, OFS_INT_CTRL_SECOND, 32'(1) << BIT_SERIAL_EN);
        issue(OP_SKIP_SERIAL, 1'b0);
        check(flags(), 32'h02);
        apb(1'b1, OFS_INT_CTRL_SECOND, 32'h0);
        issue(OP_SKIP_SERIAL, 1'b1);
        check(flags(), 32'h00);
        issue(10'h000, 1'b0);
        issue(OP_SKIP_SERIAL, 1'b0);
        setf(1'b0, 1'b1, 4'h0);
        issue(OP_SERIAL_START, 1'b0);
        check(32'(serialStart), 32'h1);
        check(flags(), 32'h00);
    endtask : t_conv_serial

    task t_timers;
        logic [7:0] a;
        int b;
        for (int i = 0; i < 4; i++) begin
            a = (i < 2) ? OFS_INT_CTRL_FIRST : OFS_INT_CTRL_SECOND;
            b = (i == 0) ? BIT_T1_EN : (i == 1) ? BIT_T2_EN : (i == 2) ? BIT_T3_EN : BIT_T4_EN;
            issue(OP_SKIP_TIMER1 + 10'(i), 1'b0);
            setf(1'b0, 1'b0, 4'h1 << i);
            apb(1'b1, a, 32'(1) << b);
            issue(OP_SKIP_TIMER1 + 10'(i), 1'b0);
            check(flags(), 32'(4'h1 << i) << 2);
            apb(1'b1, a, 32'h0);
            issue(OP_SKIP_TIMER1 + 10'(i), 1'b1);
            check(flags(), 32'h0);
            issue(10'h000, 1'b0);
        end
    endtask : t_timers

    task t_pins_mem;
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, k[2] ? OFS_EXT1_CTRL : OFS_EXT0_CTRL, 32'(k[1]) << BIT_EDGE_SEL);
            extInputZeroPin <= k[0]; extInputOnePin <= k[0];
            issue(k[2] ? OP_SKIP_EXT1 : OP_SKIP_EXT0, k[0] == k[1]);
            if (k[0] == k[1]) issue(10'h000, 1'b0);
        end
        powerDownFlag <= 1'b1;
        issue(OP_SKIP_PWRDN, 1'b1);
        issue(OP_SKIP_PWRDN, 1'b0);
        powerDownFlag <= 1'b0;
        issue(OP_SKIP_PWRDN, 1'b0);
        @(posedge clk);
        memWrEn <= 1'b1; memWrAddr <= 6'h2d; memWrData <= 4'ha;
        @(posedge clk);
        memWrEn <= 1'b0; dataPointer <= 6'h2d;
        for (int j = 0; j < 4; j++) begin
            issue({OP_SKIP_MEMBIT_HI, 2'(j)}, j[0] == 1'b0);
            if (j[0] == 1'b0) issue(10'h000, 1'b0);
        end
    endtask : t_pins_mem

    task t_regs_irq;
        apb(1'b1, OFS_EV_CLEAR, 32'h7f);
        apb(1'b1, OFS_EV_ENABLE, 32'(1) << EV_CONV);
        #1 check(32'(irq), 32'h0);
        setf(1'b1, 1'b0, 4'h0);
        apb(1'b0, OFS_EV_STATUS, 32'h0);
        check(rdv, 32'(1) << EV_CONV);
        check(32'(irq), 32'h1);
        apb(1'b1, OFS_FLAGS, 32'h0);
        check(flags(), 32'h01);
        apb(1'b1, OFS_EV_CLEAR, 32'(1) << EV_CONV);
        @(posedge clk);
        #1 check(32'(irq), 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check({errv, rdv[30:0]}, 32'h80000000);
    endtask : t_regs_irq

    initial begin
        #100000;
        err_count++;
        print_verdict();
    end

    initial begin
        err_count = 0; cmp_count = 0; pend = 1'b0;
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; instrValid = 1'b0; instrWord = 10'h000; dataPointer = 6'h00;
        memWrEn = 1'b0; memWrAddr = 6'h00; memWrData = 4'h0; extInputZeroPin = 1'b0;
        extInputOnePin = 1'b0; powerDownFlag = 1'b0; convDoneSet = 1'b0;
        serialDoneSet = 1'b0; timerSet = 4'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int r = 0; r < 8; r++) begin
            apb(1'b0, 8'(r * 4), 32'h0);
            check(rdv, 32'h0);
        end
        t_conv_serial();
        t_timers();
        t_pins_mem();
        t_regs_irq();
        print_verdict();
    end
endmodule : flag_skip_test_unit_bench
